// File: common/flash_cmd_pkg.sv
/*
 Constants and types for the flash command state machine: command
 codes, chip states and the carrier structs of the command port.
 Assumes one host writer and one array engine reporting completion.
*/
package flash_cmd_pkg;
   // ==========================================================
   // Command codes
   // ==========================================================
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
   localparam logic [7:0] CMD_PGM_SETUP_A  = 8'h10;
   localparam logic [7:0] CMD_PGM_SETUP_B  = 8'h40;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_FFP_SETUP    = 8'h30;
   localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   localparam logic [7:0] CMD_READ_QUERY   = 8'h98;
   localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
   localparam logic [7:0] CMD_OTP_SETUP    = 8'hc0;
   localparam logic [7:0] CMD_LOCK_BLOCK   = 8'h01;
   localparam logic [7:0] CMD_LOCK_DOWN    = 8'h2f;
   localparam logic [7:0] CMD_WRITE_CONFIG = 8'h03;

   // ==========================================================
   // Widths and reset values
   // ==========================================================
   localparam int          PART_W     = 4;
   localparam logic        FLAG_RESET = 1'b0;

   // ==========================================================
   // Chip states
   // ==========================================================
   typedef enum logic [4:0] {
      ST_READY, ST_LOCK_SETUP, ST_LOCK_SETUP_ES, ST_OTP_SETUP, ST_OTP_BUSY,
      ST_PGM_SETUP, ST_PGM_BUSY, ST_PGM_SUSP,
      ST_ERASE_SETUP, ST_ERASE_BUSY, ST_ERASE_SUSP,
      ST_PES_SETUP, ST_PES_BUSY, ST_PES_SUSP,
      ST_FFP_SETUP, ST_FFP_BUSY
   } chip_state_t;

   // Host command write: code and target partition
   typedef struct packed {
      logic [7:0]        code;
      logic [PART_W-1:0] part;
   } cmd_write_t;

   // Status flags shown to the host
   typedef struct packed {
      logic busy;
      logic error;
      logic lock_error;
   } cmd_status_t;
endpackage

// File: src/flash_command_state_machine.sv
/*
 Command state machine of a multi-partition flash. Host command writes
 arrive as one-cycle strobes; the array engine pulses op_done_i when the
 running operation ends. Inputs other than the asynchronous rst_b_i are synchronous to clk_i.
*/
// What this block does
// RULE1: Only one partition programs or erases at once.
// RULE2: Decode 10H/40H program, 20H erase, 30H fast.
// RULE3: Ready: FFH stays, setups enter matching state.
// RULE4: Lock setup: D0H/01H/2FH/03H ready, else lock error.
// RULE5: Program-in-erase-suspend setup: next write starts busy.
// RULE6: Double suspend: D0H resumes, others stay.
// RULE7: Erase setup confirm starts; suspend enters suspend.
// RULE8: Fast program setup: invalid follow-up errors out.
// RULE9: Lock setup in erase suspend errs back.
`timescale 1ns/1ps
`default_nettype none
module flash_command_state_machine #(
   parameter int PART_W = flash_cmd_pkg::PART_W
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_b_i,
   input  wire logic                      wr_i,
   input  wire flash_cmd_pkg::cmd_write_t cmd_i,
   input  wire logic                      op_done_i,
   output var  flash_cmd_pkg::chip_state_t state_o,
   output var  flash_cmd_pkg::cmd_status_t status_o,
   output logic                           op_start_o,
   output logic [PART_W-1:0]              active_part_o,
   output logic                           status_mode_o
);
   // ==========================================================
   // Decode helpers
   // ==========================================================
   // Program setup accepts either of two codes
   function automatic logic is_pgm(input logic [7:0] c);
      return (c == flash_cmd_pkg::CMD_PGM_SETUP_A) ||
             (c == flash_cmd_pkg::CMD_PGM_SETUP_B); // RULE2
   endfunction

   // Lock, lock-down and config-write confirms
   function automatic logic is_lock_ok(input logic [7:0] c);
      return (c == flash_cmd_pkg::CMD_CONFIRM) ||
             (c == flash_cmd_pkg::CMD_LOCK_BLOCK) ||
             (c == flash_cmd_pkg::CMD_LOCK_DOWN) ||
             (c == flash_cmd_pkg::CMD_WRITE_CONFIG); // RULE4
   endfunction

   flash_cmd_pkg::chip_state_t state_q, state_d; // Chip state
   logic err_d, lerr_d;      // Error events this cycle
   logic start_d;            // Array operation starts this cycle
   logic [7:0] c;            // Command code alias
   assign c = cmd_i.code;

   // ==========================================================
   // Next state
   // ==========================================================
   // Transitions on a command write or on completion
   always_comb begin
      state_d = state_q;
      err_d   = 1'b0;
      lerr_d  = 1'b0;
      start_d = 1'b0;
      case (state_q)
         flash_cmd_pkg::ST_READY: begin
            if (wr_i) begin
               // FFH and unknown codes leave the machine ready
               if (is_pgm(c)) begin
                  state_d = flash_cmd_pkg::ST_PGM_SETUP; // RULE3
               end else if (c == flash_cmd_pkg::CMD_ERASE_SETUP) begin
                  state_d = flash_cmd_pkg::ST_ERASE_SETUP; // RULE3
               end else if (c == flash_cmd_pkg::CMD_FFP_SETUP) begin
                  state_d = flash_cmd_pkg::ST_FFP_SETUP; // RULE3
               end else if (c == flash_cmd_pkg::CMD_LOCK_SETUP) begin
                  state_d = flash_cmd_pkg::ST_LOCK_SETUP;
               end else if (c == flash_cmd_pkg::CMD_OTP_SETUP) begin
                  state_d = flash_cmd_pkg::ST_OTP_SETUP;
               end
            end
         end
         flash_cmd_pkg::ST_LOCK_SETUP: begin
            if (wr_i) begin
               state_d = flash_cmd_pkg::ST_READY; // RULE4
               lerr_d  = !is_lock_ok(c); // RULE4
            end
         end
         flash_cmd_pkg::ST_LOCK_SETUP_ES: begin
            if (wr_i) begin
               state_d = flash_cmd_pkg::ST_ERASE_SUSP; // RULE9
               lerr_d  = !is_lock_ok(c); // RULE9
            end
         end
         flash_cmd_pkg::ST_OTP_SETUP: begin
            // Next write is the data word
            if (wr_i) begin
               state_d = flash_cmd_pkg::ST_OTP_BUSY;
               start_d = 1'b1;
            end
         end
         flash_cmd_pkg::ST_PGM_SETUP: begin
            if (wr_i) begin
               state_d = flash_cmd_pkg::ST_PGM_BUSY;
               start_d = 1'b1;
            end
         end
         flash_cmd_pkg::ST_PGM_BUSY: begin
            if (op_done_i) begin
               state_d = flash_cmd_pkg::ST_READY;
            end else if (wr_i && c == flash_cmd_pkg::CMD_SUSPEND) begin
               state_d = flash_cmd_pkg::ST_PGM_SUSP;
            end
         end
         flash_cmd_pkg::ST_PGM_SUSP: begin
            if (wr_i && c == flash_cmd_pkg::CMD_CONFIRM) begin
               state_d = flash_cmd_pkg::ST_PGM_BUSY;
            end
         end
         flash_cmd_pkg::ST_ERASE_SETUP: begin
            if (wr_i) begin
               if (c == flash_cmd_pkg::CMD_CONFIRM) begin
                  state_d = flash_cmd_pkg::ST_ERASE_BUSY; // RULE7
                  start_d = 1'b1;
               end else begin
                  state_d = flash_cmd_pkg::ST_READY; // RULE7
                  err_d   = 1'b1;
               end
            end
         end
         flash_cmd_pkg::ST_ERASE_BUSY: begin
            if (op_done_i) begin
               state_d = flash_cmd_pkg::ST_READY;
            end else if (wr_i && c == flash_cmd_pkg::CMD_SUSPEND) begin
               state_d = flash_cmd_pkg::ST_ERASE_SUSP; // RULE7
            end
         end
         flash_cmd_pkg::ST_ERASE_SUSP: begin
            if (wr_i) begin
               if (is_pgm(c)) begin
                  state_d = flash_cmd_pkg::ST_PES_SETUP;
               end else if (c == flash_cmd_pkg::CMD_CONFIRM) begin
                  state_d = flash_cmd_pkg::ST_ERASE_BUSY;
               end else if (c == flash_cmd_pkg::CMD_LOCK_SETUP) begin
                  state_d = flash_cmd_pkg::ST_LOCK_SETUP_ES;
               end
            end
         end
         flash_cmd_pkg::ST_PES_SETUP: begin
            // Any code is data here
            if (wr_i) begin
               state_d = flash_cmd_pkg::ST_PES_BUSY; // RULE5
               start_d = 1'b1;
            end
         end
         flash_cmd_pkg::ST_PES_BUSY: begin
            if (op_done_i) begin
               state_d = flash_cmd_pkg::ST_ERASE_SUSP;
            end else if (wr_i && c == flash_cmd_pkg::CMD_SUSPEND) begin
               state_d = flash_cmd_pkg::ST_PES_SUSP;
            end
         end
         flash_cmd_pkg::ST_PES_SUSP: begin
            if (wr_i && c == flash_cmd_pkg::CMD_CONFIRM) begin
               state_d = flash_cmd_pkg::ST_PES_BUSY; // RULE6
            end
         end
         flash_cmd_pkg::ST_FFP_SETUP: begin
            if (wr_i) begin
               if (c == flash_cmd_pkg::CMD_CONFIRM) begin
                  state_d = flash_cmd_pkg::ST_FFP_BUSY; // RULE8
                  start_d = 1'b1;
               end else begin
                  state_d = flash_cmd_pkg::ST_READY; // RULE8
                  err_d   = 1'b1;
               end
            end
         end
         flash_cmd_pkg::ST_OTP_BUSY, flash_cmd_pkg::ST_FFP_BUSY: begin
            if (op_done_i) begin
               state_d = flash_cmd_pkg::ST_READY;
            end
         end
         default: state_d = flash_cmd_pkg::ST_READY;
      endcase
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= flash_cmd_pkg::ST_READY;
      end else begin
         state_q <= state_d;
      end
   end
   assign state_o = state_q;

   // ==========================================================
   // Active partition: one owner while an operation is held
   // ==========================================================
   // Partition latched at start except the nested program start, kept through suspend states
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         active_part_o <= '0;
      end else if (start_d && state_q != flash_cmd_pkg::ST_PES_SETUP) begin
         active_part_o <= cmd_i.part[PART_W-1:0]; // RULE1
      end
   end

   // Start pulse to array engine; only one operation at a time
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_start_o <= 1'b0;
      end else begin
         op_start_o <= start_d; // RULE1
      end
   end

   // ==========================================================
   // Status flags
   // ==========================================================
   // Errors sticky until clear-status; a new error wins over clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_o <= '{busy: 1'b0, error: flash_cmd_pkg::FLAG_RESET,
                       lock_error: flash_cmd_pkg::FLAG_RESET};
      end else begin
         status_o.busy <= (state_d == flash_cmd_pkg::ST_PGM_BUSY) ||
                          (state_d == flash_cmd_pkg::ST_ERASE_BUSY) ||
                          (state_d == flash_cmd_pkg::ST_PES_BUSY) ||
                          (state_d == flash_cmd_pkg::ST_OTP_BUSY) ||
                          (state_d == flash_cmd_pkg::ST_FFP_BUSY);
         if (err_d) begin
            status_o.error <= 1'b1;
         end else if (wr_i && state_q == flash_cmd_pkg::ST_READY &&
                      c == flash_cmd_pkg::CMD_CLEAR_STATUS) begin
            status_o.error <= 1'b0;
         end
         if (lerr_d) begin
            status_o.lock_error <= 1'b1;
         end else if (wr_i && state_q == flash_cmd_pkg::ST_READY &&
                      c == flash_cmd_pkg::CMD_CLEAR_STATUS) begin
            status_o.lock_error <= 1'b0;
         end
      end
   end

   // Read mode: status after 70H, array after FFH, ID/query off status
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_mode_o <= 1'b0;
      end else if (wr_i) begin
         if (c == flash_cmd_pkg::CMD_READ_STATUS) begin
            status_mode_o <= 1'b1;
         end else if (c == flash_cmd_pkg::CMD_READ_ARRAY ||
                      c == flash_cmd_pkg::CMD_READ_ID ||
                      c == flash_cmd_pkg::CMD_READ_QUERY) begin
            status_mode_o <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/flash_fsm_monitor.sv
/*
 Checker of the command state machine, watching the top ports only.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_fsm_monitor #(
   parameter int PART_W = 4
) (
   input wire logic                       clk_i,
   input wire logic                       rst_b_i,
   input wire logic                       wr_i,
   input wire flash_cmd_pkg::cmd_write_t  cmd_i,
   input wire logic                       op_done_i,
   input wire flash_cmd_pkg::chip_state_t state_o,
   input wire flash_cmd_pkg::cmd_status_t status_o,
   input wire logic                       op_start_o,
   input wire logic [PART_W-1:0]          active_part_o
);
   // ==========================================================
   // Helpers
   // ==========================================================
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [7:0]                 c;  // Code written
   logic                       lk; // Accepted lock confirm
   flash_cmd_pkg::chip_state_t s;  // Present state
   assign c = cmd_i.code;
   assign lk = c inside {8'hd0, 8'h01, 8'h2f, 8'h03};
   assign s = state_o;
   // ==========================================================
   // Assertions
   // ==========================================================
   ready_setup_a : assert property (
      s == flash_cmd_pkg::ST_READY && wr_i
      && c inside {8'h10, 8'h40} |=> s == flash_cmd_pkg::ST_PGM_SETUP)
      else $error("program setup not entered");
   lock_err_a : assert property (
      s == flash_cmd_pkg::ST_LOCK_SETUP && wr_i
      && !lk |=> s == flash_cmd_pkg::ST_READY && status_o.lock_error)
      else $error("bad lock confirm not flagged");
   nest_data_a : assert property (
      s == flash_cmd_pkg::ST_PES_SETUP && wr_i
      |=> s == flash_cmd_pkg::ST_PES_BUSY && op_start_o)
      else $error("nested program did not start");
   dbl_hold_a : assert property (
      s == flash_cmd_pkg::ST_PES_SUSP && wr_i
      && c != 8'hd0 |=> s == flash_cmd_pkg::ST_PES_SUSP)
      else $error("double suspend left early");
   erase_go_a : assert property (s == flash_cmd_pkg::ST_ERASE_SETUP
      && wr_i && c == 8'hd0 |=> s == flash_cmd_pkg::ST_ERASE_BUSY
      && op_start_o && status_o.busy)
      else $error("erase did not start");
   erase_susp_a : assert property (s == flash_cmd_pkg::ST_ERASE_BUSY
      && wr_i && c == 8'hb0 && !op_done_i
      |=> s == flash_cmd_pkg::ST_ERASE_SUSP)
      else $error("erase not suspended");
   fast_err_a : assert property (
      s == flash_cmd_pkg::ST_FFP_SETUP && wr_i
      && c != 8'hd0 |=> s == flash_cmd_pkg::ST_READY && status_o.error)
      else $error("fast program error missing");
   lock_susp_a : assert property (s == flash_cmd_pkg::ST_LOCK_SETUP_ES
      && wr_i && !lk |=> s == flash_cmd_pkg::ST_ERASE_SUSP
      && status_o.lock_error)
      else $error("lock error in suspend missing");
   one_part_a : assert property (status_o.busy
      |=> !op_start_o && $stable(active_part_o))
      else $error("active partition moved while busy");
   // Main scenarios reached
   erase_c : cover property (s == flash_cmd_pkg::ST_ERASE_BUSY);
   pgm_susp_c : cover property (s == flash_cmd_pkg::ST_PGM_SUSP);
   dbl_c : cover property (s == flash_cmd_pkg::ST_PES_SUSP);
   lock_c : cover property (status_o.lock_error);
endmodule
bind flash_command_state_machine flash_fsm_monitor #(.PART_W(PART_W)) mon (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .wr_i(wr_i), .cmd_i(cmd_i),
   .op_done_i(op_done_i), .state_o(state_o), .status_o(status_o),
   .op_start_o(op_start_o), .active_part_o(active_part_o));
`default_nettype wire

// File: tb/flash_host_model.sv
/*
 Host model: command writes and array completion pulses.
 Assumes its tasks are called from one bench process.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
   input  wire logic                     clk_i,
   output var  logic                     wr_o,
   output var  flash_cmd_pkg::cmd_write_t cmd_o,
   output var  logic                     done_o
);
   // ==========================================================
   // Drivers
   // ==========================================================
   initial begin
      wr_o = 1'b0;
      cmd_o = '0;
      done_o = 1'b0;
   end
   // One write held for one edge; one operation at a time
   task automatic send(input logic [7:0] c, input logic [3:0] p);
      @(posedge clk_i) #2;
      wr_o = 1'b1;
      cmd_o = {c, p};
      @(posedge clk_i) #2;
      wr_o = 1'b0;
      cmd_o = ~cmd_o; // Idle bus shows no stale code
   endtask
   // Completion pulse of the running operation
   task automatic finish();
      @(posedge clk_i) #2;
      done_o = 1'b1;
      @(posedge clk_i) #2;
      done_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/tb_flash_command_state_machine.sv
/*
 Bench: scripted and random command writes checked against a model.
 Assumes the host model drives all design inputs except clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_state_machine;
   // ==========================================================
   // Signals and model state
   // ==========================================================
   logic                       clk_i, rst_b_i; // Clock, reset
   logic                       wr, done, op_st; // Host and start pulses
   flash_cmd_pkg::cmd_write_t  cmd;            // Command from host
   flash_cmd_pkg::chip_state_t st, ms;         // Design and model state
   flash_cmd_pkg::cmd_status_t sts;            // Design flags
   logic [3:0]                 ap_o, ap;       // Design and model part
   logic                       er, le;         // Model flags
   logic                       sm, smode;      // Model and design read mode
   logic [31:0]                rnd = 32'h13963dee;
   int                         n_fail = 0;
   int                         n_tests = 0;
   // Script; ee marks completion, cc a random non-resume code
   logic [7:0] sq [] = '{8'hff, 8'h10, 8'h12, 8'hee,
      8'h20, 8'h55, 8'h50, 8'h20, 8'hd0, 8'hb0, 8'h60, 8'h55,
      8'h40, 8'hd0, 8'hb0, 8'h70, 8'h90, 8'h98, 8'hcc, 8'hcc, 8'hcc,
      8'hd0, 8'hee, 8'hd0, 8'hee, 8'h50, 8'h30, 8'h55, 8'h50,
      8'h30, 8'hd0, 8'hee, 8'h60, 8'hd0, 8'h60, 8'h01, 8'h60, 8'h2f,
      8'h60, 8'h03, 8'h60, 8'h55, 8'h50,
      8'h10, 8'h77, 8'hb0, 8'h70, 8'hd0, 8'hee, 8'hc0, 8'h34, 8'hee};
   flash_host_model host (.clk_i(clk_i), .wr_o(wr), .cmd_o(cmd),
      .done_o(done));
   flash_command_state_machine DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .wr_i(wr), .cmd_i(cmd), .op_done_i(done), .state_o(st),
      .status_o(sts), .op_start_o(op_st), .active_part_o(ap_o),
      .status_mode_o(smode));
   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string n, logic [4:0] s, logic [4:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Compare state, flags and active partition with the model
   task automatic look();
      logic b;
      b = ms inside {flash_cmd_pkg::ST_PGM_BUSY, flash_cmd_pkg::ST_FFP_BUSY,
         flash_cmd_pkg::ST_ERASE_BUSY, flash_cmd_pkg::ST_PES_BUSY,
         flash_cmd_pkg::ST_OTP_BUSY};
      chk("state", 5'(st), 5'(ms));
      chk("flags", 5'(sts), {2'h0, b, er, le});
      chk("part", 5'(ap_o), 5'(ap));
      chk("mode", 5'(smode), 5'(sm));
   endtask
   // One write: advance the model, send, compare
   task automatic step(input logic [7:0] c);
      logic s, r, v;
      logic [3:0] p;
      s = 1'b0;
      r = 1'b0;
      v = c inside {8'hd0, 8'h01, 8'h2f, 8'h03};
      p = rnd[3:0];
      rnd = lfsr(rnd);
      case (ms)
         flash_cmd_pkg::ST_READY: begin
            if (c inside {8'h10, 8'h40}) ms = flash_cmd_pkg::ST_PGM_SETUP;
            if (c == 8'h20) ms = flash_cmd_pkg::ST_ERASE_SETUP;
            if (c == 8'h30) ms = flash_cmd_pkg::ST_FFP_SETUP;
            if (c == 8'h60) ms = flash_cmd_pkg::ST_LOCK_SETUP;
            if (c == 8'hc0) ms = flash_cmd_pkg::ST_OTP_SETUP;
            if (c == 8'h50) {er, le} = 2'h0;
         end
         flash_cmd_pkg::ST_LOCK_SETUP: begin
            le = le | !v;
            ms = flash_cmd_pkg::ST_READY;
         end
         flash_cmd_pkg::ST_LOCK_SETUP_ES: begin
            le = le | !v;
            ms = flash_cmd_pkg::ST_ERASE_SUSP;
         end
         flash_cmd_pkg::ST_ERASE_SETUP, flash_cmd_pkg::ST_FFP_SETUP: begin
            s = c == 8'hd0;
            er = er | !s;
            if (!s) ms = flash_cmd_pkg::ST_READY;
            else if (ms == flash_cmd_pkg::ST_FFP_SETUP)
               ms = flash_cmd_pkg::ST_FFP_BUSY;
            else ms = flash_cmd_pkg::ST_ERASE_BUSY;
         end
         flash_cmd_pkg::ST_PGM_SETUP, flash_cmd_pkg::ST_OTP_SETUP: begin
            // Any code is the data word
            s = 1'b1;
            ms = (ms == flash_cmd_pkg::ST_PGM_SETUP) ?
               flash_cmd_pkg::ST_PGM_BUSY : flash_cmd_pkg::ST_OTP_BUSY;
         end
         flash_cmd_pkg::ST_PES_SETUP: begin
            s = 1'b1;
            ms = flash_cmd_pkg::ST_PES_BUSY;
         end
         flash_cmd_pkg::ST_PGM_BUSY:
            if (c == 8'hb0) ms = flash_cmd_pkg::ST_PGM_SUSP;
         flash_cmd_pkg::ST_PGM_SUSP:
            if (c == 8'hd0) begin
               r = 1'b1;
               ms = flash_cmd_pkg::ST_PGM_BUSY;
            end
         flash_cmd_pkg::ST_ERASE_BUSY:
            if (c == 8'hb0) ms = flash_cmd_pkg::ST_ERASE_SUSP;
         flash_cmd_pkg::ST_PES_BUSY:
            if (c == 8'hb0) ms = flash_cmd_pkg::ST_PES_SUSP;
         flash_cmd_pkg::ST_PES_SUSP:
            if (c == 8'hd0) begin
               r = 1'b1;
               ms = flash_cmd_pkg::ST_PES_BUSY;
            end
         flash_cmd_pkg::ST_ERASE_SUSP: begin
            if (c inside {8'h10, 8'h40}) ms = flash_cmd_pkg::ST_PES_SETUP;
            if (c == 8'h60) ms = flash_cmd_pkg::ST_LOCK_SETUP_ES;
            if (c == 8'hd0) begin
               r = 1'b1;
               ms = flash_cmd_pkg::ST_ERASE_BUSY;
            end
         end
         default: ;
      endcase
      // Read mode follows every write, whatever the state
      if (c == 8'h70) sm = 1'b1;
      else if (c inside {8'hff, 8'h90, 8'h98}) sm = 1'b0;
      host.send(c, p);
      if (s && ms != flash_cmd_pkg::ST_PES_BUSY) ap = p;
      look();
      if (!r) chk("start", 5'(op_st), 5'(s));
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence
   // ==========================================================
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Script needs about 120 cycles; allow over thirty times that
   initial begin
      #100us;
      n_fail++;
      close_out();
   end
   initial begin
      rst_b_i = 1'b0;
      ms = flash_cmd_pkg::ST_READY;
      {ap, er, le, sm} = '0;
      repeat (3) @(posedge clk_i);
      #2 rst_b_i = 1'b1;
      look();
      foreach (sq[i]) begin
         if (sq[i] == 8'hee) begin
            ms = (ms == flash_cmd_pkg::ST_PES_BUSY) ?
               flash_cmd_pkg::ST_ERASE_SUSP : flash_cmd_pkg::ST_READY;
            host.finish();
            look();
         end
         else if (sq[i] == 8'hcc)
            step(rnd[15:8] == 8'hd0 ? 8'h70 : rnd[15:8]);
         else step(sq[i]);
      end
      // Mid-run reset from a setup state with an error pending
      step(8'h20);
      step(8'h55);
      step(8'h30);
      @(posedge clk_i) #2 rst_b_i = 1'b0;
      ms = flash_cmd_pkg::ST_READY;
      {ap, er, le, sm} = '0;
      repeat (2) @(posedge clk_i);
      #1 look();
      #1 rst_b_i = 1'b1;
      step(8'h10);
      close_out();
   end
endmodule
`default_nettype wire
